// [design/fpe_pkg.sv]
// constants and types shared by the flash program/erase control ends
package fpe_pkg;
    // special function register addresses
    localparam logic [7:0] FPE_SFR_ERASE_CMD = 8'h94;
    localparam logic [7:0] FPE_SFR_WRITE_CTL = 8'hb2;
    localparam logic [7:0] FPE_SFR_BANK_SEL = 8'hb6;
    localparam logic [7:0] FPE_SFR_PAGE_NUM = 8'hb7;
    localparam logic [7:0] FPE_SFR_INT_FLAGS = 8'he8;
    // erase command keys
    localparam logic [7:0] FPE_KEY_PAGE = 8'h55;
    localparam logic [7:0] FPE_KEY_MASS = 8'haa;
    localparam logic [7:0] FPE_KEY_DONE = 8'h00;
    // field positions
    localparam int FPE_PROG_BIT = 0;
    localparam int FPE_BULK_BIT = 1;
    localparam int FPE_PAGE_LSB = 2;
    localparam int FPE_COL0_BIT = 2;
    localparam int FPE_COL1_BIT = 3;
    localparam int FPE_XADDR_TOP = 15;
    // widths
    localparam int FPE_PAGE_W = 7;
    localparam int FPE_BANK_W = 3;
    localparam int FPE_FADDR_W = 18;
    // reset values
    localparam logic [7:0] FPE_RST_ZERO = 8'h00;
    localparam logic [2:0] FPE_RST_BANK = 3'h1;
    // controller register byte offsets on the AHB-Lite slave
    localparam logic [7:0] FPE_REG_SFR_CMD = 8'h00;
    localparam logic [7:0] FPE_REG_XMOVE = 8'h04;
    localparam logic [7:0] FPE_REG_CTRL = 8'h08;
    localparam logic [7:0] FPE_REG_STATUS = 8'h0c;
    localparam logic [7:0] FPE_REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] FPE_REG_IRQ_MASK = 8'h14;
    localparam logic [31:0] FPE_RST_WORD = 32'h0000_0000;
    // controller field positions
    localparam int FPE_CMD_RD_BIT = 16;
    localparam int FPE_CTRL_INTS = 0;
    localparam int FPE_CTRL_DBG = 1;
    localparam int FPE_CTRL_AUTO_BULK = 2;
    localparam int FPE_CTRL_AUTO_PROG = 3;
    localparam int FPE_IRQ_W = 3;
    localparam int FPE_IRQ_RDONE = 0;
    localparam int FPE_IRQ_EDONE = 1;
    localparam int FPE_IRQ_REFUSED = 2;

    typedef enum logic [1:0]
    {
        FPE_IDLE = 2'b00,
        FPE_ERASING = 2'b01,
        FPE_WAIT_ZERO = 2'b10,
        FPE_WAIT_DONE = 2'b11
    } fpe_erase_st_t;

    typedef enum logic [2:0]
    {
        FPE_H_IDLE = 3'b000,
        FPE_H_PRE = 3'b001,
        FPE_H_ACC = 3'b010,
        FPE_H_RD = 3'b011,
        FPE_H_POST = 3'b100
    } fpe_host_st_t;
endpackage : fpe_pkg

// [design/fpe_sfr_if.sv]
// link between the firmware side controller and the flash control device
`timescale 1ns/1ps
`default_nettype none
interface fpe_sfr_if;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic sfr_rvalid;
    logic ints_enabled;
    logic debug_port_en;
    logic xmv_wr;
    logic [15:0] xmv_addr;
    logic [7:0] xmv_data;
    logic erase_busy;

    modport dev
    (
        input sfr_wr, sfr_rd, sfr_addr, sfr_wdata, ints_enabled, debug_port_en,
        input xmv_wr, xmv_addr, xmv_data,
        output sfr_rdata, sfr_rvalid, erase_busy
    );

    modport ctl
    (
        output sfr_wr, sfr_rd, sfr_addr, sfr_wdata, ints_enabled, debug_port_en,
        output xmv_wr, xmv_addr, xmv_data,
        input sfr_rdata, sfr_rvalid, erase_busy
    );
endinterface : fpe_sfr_if
`default_nettype wire

// [design/fpe_dev.sv]
// flash program/erase control seen from the processor's special function registers
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module fpe_dev
    import fpe_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_B,
    // register port
    fpe_sfr_if.dev SFR,
    // flash array erase
    output logic FLASH_PAGE_ERASE,
    output logic FLASH_MASS_ERASE,
    output logic [FPE_PAGE_W-1:0] FLASH_PAGE,
    input wire logic FLASH_ERASE_DONE,
    // flash array byte program
    output logic FLASH_WR,
    output logic [FPE_FADDR_W-1:0] FLASH_ADDR,
    output logic [7:0] FLASH_DATA,
    // external ram store
    output logic XRAM_WR,
    output logic [15:0] XRAM_ADDR,
    output logic [7:0] XRAM_DATA,
    // collision events from the flash
    input wire logic [1:0] COLLISION_EVT
);
    fpe_erase_st_t state_q;
    fpe_erase_st_t state_d;
    logic bulk_erase_enable_q;
    logic program_write_enable_q;
    logic [5:0] erase_page_number_q;
    logic [FPE_BANK_W-1:0] bank_select_q;
    logic collision_flag_0_q;
    logic collision_flag_1_q;
    logic cmd_wr;
    logic zero_wr;
    logic page_start;
    logic mass_start;

    assign cmd_wr = SFR.sfr_wr && (SFR.sfr_addr == FPE_SFR_ERASE_CMD);
    assign zero_wr = cmd_wr && (SFR.sfr_wdata == FPE_KEY_DONE);
    // keys only count from idle, so a stray key cannot disturb a running erase
    assign page_start = cmd_wr && (state_q == FPE_IDLE) && (SFR.sfr_wdata == FPE_KEY_PAGE);
    assign mass_start = cmd_wr && (state_q == FPE_IDLE) && (SFR.sfr_wdata == FPE_KEY_MASS)
        && bulk_erase_enable_q && SFR.debug_port_en;

    // any other command value falls through every branch below unchanged
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            FPE_IDLE:
            begin
                if (page_start || mass_start)
                begin
                    state_d = FPE_ERASING;
                end
            end
            FPE_ERASING:
            begin
                if (FLASH_ERASE_DONE && zero_wr)
                begin
                    state_d = FPE_IDLE;
                end
                else if (FLASH_ERASE_DONE)
                begin
                    state_d = FPE_WAIT_ZERO;
                end
                else if (zero_wr)
                begin
                    state_d = FPE_WAIT_DONE;
                end
            end
            FPE_WAIT_ZERO:
            begin
                if (zero_wr)
                begin
                    state_d = FPE_IDLE;
                end
            end
            FPE_WAIT_DONE:
            begin
                if (FLASH_ERASE_DONE)
                begin
                    state_d = FPE_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            state_q <= FPE_IDLE;
            SFR.erase_busy <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            SFR.erase_busy <= (state_d != FPE_IDLE);
        end
    end

    // erase strobes to the array, one cycle each
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            FLASH_PAGE_ERASE <= 1'b0;
            FLASH_MASS_ERASE <= 1'b0;
            FLASH_PAGE <= '0;
        end
        else
        begin
            FLASH_PAGE_ERASE <= page_start;
            FLASH_MASS_ERASE <= mass_start;
            if (page_start)
            begin
                // only seven page bits exist, so the bank contributes its low bit
                FLASH_PAGE <= {bank_select_q[0], erase_page_number_q};
            end
        end
    end

    // write-only erase setup registers
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            bulk_erase_enable_q <= 1'b0;
            erase_page_number_q <= FPE_RST_ZERO[5:0];
        end
        else
        begin
            if (page_start || mass_start)
            begin
                // enable is spent by any erase so it must be armed again
                bulk_erase_enable_q <= 1'b0;
            end
            else if (SFR.sfr_wr && (SFR.sfr_addr == FPE_SFR_WRITE_CTL))
            begin
                bulk_erase_enable_q <= SFR.sfr_wdata[FPE_BULK_BIT];
            end
            if (SFR.sfr_wr && (SFR.sfr_addr == FPE_SFR_PAGE_NUM))
            begin
                erase_page_number_q <= SFR.sfr_wdata[7:FPE_PAGE_LSB];
            end
        end
    end

    // program enable and bank select
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            program_write_enable_q <= 1'b0;
            bank_select_q <= FPE_RST_BANK;
        end
        else
        begin
            if (SFR.sfr_wr && (SFR.sfr_addr == FPE_SFR_WRITE_CTL) && !SFR.ints_enabled)
            begin
                program_write_enable_q <= SFR.sfr_wdata[FPE_PROG_BIT];
            end
            if (SFR.sfr_wr && (SFR.sfr_addr == FPE_SFR_BANK_SEL))
            begin
                bank_select_q <= SFR.sfr_wdata[FPE_BANK_W-1:0];
            end
        end
    end

    // collision flags: a hardware event in the same cycle as a write wins
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            collision_flag_0_q <= 1'b0;
            collision_flag_1_q <= 1'b0;
        end
        else if (SFR.sfr_wr && (SFR.sfr_addr == FPE_SFR_INT_FLAGS))
        begin
            collision_flag_0_q <= SFR.sfr_wdata[FPE_COL0_BIT] | COLLISION_EVT[0];
            collision_flag_1_q <= SFR.sfr_wdata[FPE_COL1_BIT] | COLLISION_EVT[1];
        end
        else
        begin
            collision_flag_0_q <= collision_flag_0_q | COLLISION_EVT[0];
            collision_flag_1_q <= collision_flag_1_q | COLLISION_EVT[1];
        end
    end

    // register reads answer one cycle later; write-only fields read zero
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            SFR.sfr_rvalid <= 1'b0;
            SFR.sfr_rdata <= FPE_RST_ZERO;
        end
        else
        begin
            SFR.sfr_rvalid <= SFR.sfr_rd;
            if (SFR.sfr_rd)
            begin
                unique case (SFR.sfr_addr)
                    FPE_SFR_WRITE_CTL: SFR.sfr_rdata <= {7'h00, program_write_enable_q};
                    FPE_SFR_BANK_SEL: SFR.sfr_rdata <= {5'h00, bank_select_q};
                    FPE_SFR_INT_FLAGS: SFR.sfr_rdata <= {4'h0, collision_flag_1_q, collision_flag_0_q, 2'h0};
                    default: SFR.sfr_rdata <= FPE_RST_ZERO;
                endcase
            end
        end
    end

    // external moves go to flash or ram depending on the program enable
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            FLASH_WR <= 1'b0;
            FLASH_ADDR <= '0;
            FLASH_DATA <= FPE_RST_ZERO;
            XRAM_WR <= 1'b0;
            XRAM_ADDR <= 16'h0000;
            XRAM_DATA <= FPE_RST_ZERO;
        end
        else
        begin
            FLASH_WR <= SFR.xmv_wr && program_write_enable_q;
            XRAM_WR <= SFR.xmv_wr && !program_write_enable_q;
            if (SFR.xmv_wr && program_write_enable_q)
            begin
                FLASH_DATA <= SFR.xmv_data;
                if (SFR.xmv_addr[FPE_XADDR_TOP])
                begin
                    FLASH_ADDR <= {bank_select_q, SFR.xmv_addr[14:0]};
                end
                else
                begin
                    FLASH_ADDR <= {3'h0, SFR.xmv_addr[14:0]};
                end
            end
            if (SFR.xmv_wr && !program_write_enable_q)
            begin
                XRAM_ADDR <= SFR.xmv_addr;
                XRAM_DATA <= SFR.xmv_data;
            end
        end
    end
endmodule : fpe_dev
`default_nettype wire

// [design/fpe_host.sv]
// firmware side controller: AHB-Lite registers turned into register-port accesses
`timescale 1ns/1ps
`default_nettype none
module fpe_host
    import fpe_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_B,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // interrupt
    output logic IRQ,
    // register port toward the device
    fpe_sfr_if.ctl SFR
);
    fpe_host_st_t st_q;
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_q;
    logic [3:0] ctrl_q;
    logic [16:0] cmd_q;
    logic [7:0] rdbuf_q;
    logic [FPE_IRQ_W-1:0] irq_stat_q;
    logic [FPE_IRQ_W-1:0] irq_mask_q;
    logic [FPE_IRQ_W-1:0] ev;
    logic busy_prev_q;
    logic cmd_wr;
    logic xmv_wr;

    assign cmd_wr = wr_pend_q && (addr_q == FPE_REG_SFR_CMD);
    assign xmv_wr = wr_pend_q && (addr_q == FPE_REG_XMOVE);

    // address phase capture; reads take one wait state so hrdata leaves a flop
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            HRDATA <= FPE_RST_WORD;
        end
        else
        begin
            wr_pend_q <= HSEL && HTRANS[1] && HREADY && HWRITE;
            rd_pend_q <= HSEL && HTRANS[1] && HREADY && !HWRITE;
            if (HSEL && HTRANS[1] && HREADY)
            begin
                addr_q <= {HADDR[7:2], 2'b00};
            end
            HREADYOUT <= !(HSEL && HTRANS[1] && HREADY && !HWRITE);
            if (rd_pend_q)
            begin
                unique case (addr_q)
                    FPE_REG_CTRL: HRDATA <= {28'h0, ctrl_q};
                    FPE_REG_STATUS: HRDATA <= {16'h0, rdbuf_q, 6'h00, SFR.erase_busy, st_q != FPE_H_IDLE};
                    FPE_REG_IRQ_STAT: HRDATA <= {29'h0, irq_stat_q};
                    FPE_REG_IRQ_MASK: HRDATA <= {29'h0, irq_mask_q};
                    default: HRDATA <= FPE_RST_WORD;
                endcase
            end
        end
    end

    // control, mask and sticky status registers
    always_comb
    begin
        ev = '0;
        ev[FPE_IRQ_RDONE] = SFR.sfr_rvalid;
        ev[FPE_IRQ_EDONE] = busy_prev_q && !SFR.erase_busy;
        ev[FPE_IRQ_REFUSED] = (cmd_wr || xmv_wr) && (st_q != FPE_H_IDLE);
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            ctrl_q <= 4'h0;
            irq_mask_q <= '0;
            irq_stat_q <= '0;
            busy_prev_q <= 1'b0;
            IRQ <= 1'b0;
        end
        else
        begin
            busy_prev_q <= SFR.erase_busy;
            if (wr_pend_q && (addr_q == FPE_REG_CTRL))
            begin
                ctrl_q <= HWDATA[3:0];
            end
            if (wr_pend_q && (addr_q == FPE_REG_IRQ_MASK))
            begin
                irq_mask_q <= HWDATA[FPE_IRQ_W-1:0];
            end
            // a new event beats a write-one-to-clear in the same cycle
            if (wr_pend_q && (addr_q == FPE_REG_IRQ_STAT))
            begin
                irq_stat_q <= (irq_stat_q & ~HWDATA[FPE_IRQ_W-1:0]) | ev;
            end
            else
            begin
                irq_stat_q <= irq_stat_q | ev;
            end
            IRQ <= |(irq_stat_q & irq_mask_q);
        end
    end

    // access sequencer; commands arriving while busy are dropped and flagged
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
        begin
            st_q <= FPE_H_IDLE;
            cmd_q <= '0;
            rdbuf_q <= 8'h00;
            SFR.sfr_wr <= 1'b0;
            SFR.sfr_rd <= 1'b0;
            SFR.sfr_addr <= 8'h00;
            SFR.sfr_wdata <= 8'h00;
            SFR.xmv_wr <= 1'b0;
            SFR.xmv_addr <= 16'h0000;
            SFR.xmv_data <= 8'h00;
            SFR.ints_enabled <= 1'b0;
            SFR.debug_port_en <= 1'b0;
        end
        else
        begin
            SFR.ints_enabled <= ctrl_q[FPE_CTRL_INTS];
            SFR.debug_port_en <= ctrl_q[FPE_CTRL_DBG];
            SFR.sfr_wr <= 1'b0;
            SFR.sfr_rd <= 1'b0;
            SFR.xmv_wr <= 1'b0;
            if (SFR.sfr_rvalid)
            begin
                rdbuf_q <= SFR.sfr_rdata;
            end
            unique case (st_q)
                FPE_H_IDLE:
                begin
                    if (cmd_wr)
                    begin
                        cmd_q <= HWDATA[16:0];
                        if (ctrl_q[FPE_CTRL_AUTO_BULK] && !HWDATA[FPE_CMD_RD_BIT]
                            && (HWDATA[7:0] == FPE_SFR_ERASE_CMD) && (HWDATA[15:8] == FPE_KEY_MASS))
                        begin
                            st_q <= FPE_H_PRE;
                        end
                        else
                        begin
                            st_q <= FPE_H_ACC;
                        end
                    end
                    else if (xmv_wr)
                    begin
                        SFR.xmv_wr <= 1'b1;
                        SFR.xmv_addr <= HWDATA[15:0];
                        SFR.xmv_data <= HWDATA[23:16];
                        if (ctrl_q[FPE_CTRL_AUTO_PROG])
                        begin
                            st_q <= FPE_H_POST;
                        end
                    end
                end
                FPE_H_PRE:
                begin
                    SFR.sfr_wr <= 1'b1;
                    SFR.sfr_addr <= FPE_SFR_WRITE_CTL;
                    SFR.sfr_wdata <= 8'h02;
                    st_q <= FPE_H_ACC;
                end
                FPE_H_ACC:
                begin
                    SFR.sfr_wr <= !cmd_q[FPE_CMD_RD_BIT];
                    SFR.sfr_rd <= cmd_q[FPE_CMD_RD_BIT];
                    SFR.sfr_addr <= cmd_q[7:0];
                    SFR.sfr_wdata <= cmd_q[15:8];
                    st_q <= cmd_q[FPE_CMD_RD_BIT] ? FPE_H_RD : FPE_H_IDLE;
                end
                FPE_H_RD:
                begin
                    if (SFR.sfr_rvalid)
                    begin
                        st_q <= FPE_H_IDLE;
                    end
                end
                FPE_H_POST:
                begin
                    SFR.sfr_wr <= 1'b1;
                    SFR.sfr_addr <= FPE_SFR_WRITE_CTL;
                    SFR.sfr_wdata <= 8'h00;
                    st_q <= FPE_H_IDLE;
                end
                default:
                begin
                    st_q <= FPE_H_IDLE;
                end
            endcase
        end
    end
endmodule : fpe_host
`default_nettype wire

// [sim/fpe_sfr_chk.sv]
// assertions on the register port between controller and device
`timescale 1ns/1ps
`default_nettype none
module fpe_sfr_chk
    import fpe_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST_B,
    // register port
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_rvalid,
    input wire logic ints_enabled,
    input wire logic debug_port_en,
    input wire logic erase_busy
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_B);
    logic cmd_wr;
    logic zero_wr;
    logic zero_seen_q;
    logic prog_q;
    assign cmd_wr = sfr_wr && sfr_addr == FPE_SFR_ERASE_CMD;
    assign zero_wr = cmd_wr && sfr_wdata == FPE_KEY_DONE;
    // the zero write may come before the array reports done
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B || !erase_busy)
            zero_seen_q <= 1'b0;
        else if (zero_wr)
            zero_seen_q <= 1'b1;
    end
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_B)
            prog_q <= 1'b0;
        else if (sfr_wr && sfr_addr == FPE_SFR_WRITE_CTL && !ints_enabled)
            prog_q <= sfr_wdata[FPE_PROG_BIT];
    end
    page_start_a: assert property (cmd_wr && sfr_wdata == FPE_KEY_PAGE && !erase_busy |=> erase_busy)
        else $error("page key did not start an erase");
    bad_key_a: assert property (cmd_wr && !erase_busy && sfr_wdata != FPE_KEY_PAGE
        && sfr_wdata != FPE_KEY_MASS |=> !erase_busy)
        else $error("unknown key started an erase");
    mass_gate_a: assert property (cmd_wr && !erase_busy && !debug_port_en && sfr_wdata == FPE_KEY_MASS
        |=> !erase_busy)
        else $error("mass erase ran with debug port off");
    zero_done_a: assert property (erase_busy && !zero_seen_q && !zero_wr |=> erase_busy)
        else $error("erase ended without zero write");
    prog_read_a: assert property (sfr_rd && sfr_addr == FPE_SFR_WRITE_CTL
        |=> sfr_rvalid && sfr_rdata == {7'h00, prog_q})
        else $error("program enable read back wrong");
    wo_read_a: assert property (sfr_rd && (sfr_addr == FPE_SFR_ERASE_CMD || sfr_addr == FPE_SFR_PAGE_NUM)
        |=> sfr_rdata == 8'h00)
        else $error("write-only register read nonzero");
    flag_read_a: assert property (sfr_rd && sfr_addr == FPE_SFR_INT_FLAGS
        |=> sfr_rvalid && sfr_rdata[7:4] == 4'h0 && sfr_rdata[1:0] == 2'h0)
        else $error("flag register read has stray bits");
    rvalid_cause_a: assert property (sfr_rvalid |-> $past(sfr_rd))
        else $error("read answer without request");
    page_c: cover property (cmd_wr && sfr_wdata == FPE_KEY_PAGE && !erase_busy ##1 erase_busy);
    mass_c: cover property (cmd_wr && sfr_wdata == FPE_KEY_MASS && debug_port_en && !erase_busy ##1 erase_busy);
    done_c: cover property ($fell(erase_busy));
endmodule : fpe_sfr_chk
`default_nettype wire

// [sim/flash_program_erase_control_bench.sv]
// self-checking bench for both ends of the flash program/erase control
`timescale 1ns/1ps
`default_nettype none
module flash_program_erase_control_bench
    import fpe_pkg::*;
;
    logic clk, rst_b, hsel, hwrite, hready, done, pe, me, fw, xw, irq, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, col;
    logic [17:0] faddr;
    logic [6:0] fpage;
    logic [15:0] xaddr;
    logic [7:0] fdata, xdata;
    int mismatches, compares, npe, nme, nfw, nxw;
    logic [2:0] rows [4] = '{3'b011, 3'b101, 3'b000, 3'b110};
    logic [7:0] ra [5] = '{8'h94, 8'hb7, 8'hb6, 8'hb2, 8'he8};
    logic [7:0] re [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
    logic [7:0] ha [4] = '{FPE_REG_CTRL, FPE_REG_STATUS, FPE_REG_IRQ_MASK, 8'h20};
    logic [7:0] bk [4] = '{8'h00, 8'h54, 8'hab, 8'hff};
    fpe_sfr_if sfr();
    fpe_dev u_fpe_dev(.REF_CLK(clk), .RST_B(rst_b), .SFR(sfr), .FLASH_PAGE_ERASE(pe), .FLASH_MASS_ERASE(me),
        .FLASH_PAGE(fpage), .FLASH_ERASE_DONE(done), .FLASH_WR(fw), .FLASH_ADDR(faddr), .FLASH_DATA(fdata),
        .XRAM_WR(xw), .XRAM_ADDR(xaddr), .XRAM_DATA(xdata), .COLLISION_EVT(col));
    fpe_host u_fpe_host(.REF_CLK(clk), .RST_B(rst_b), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .IRQ(irq), .SFR(sfr));
    fpe_sfr_chk u_fpe_sfr_chk(.REF_CLK(clk), .RST_B(rst_b), .sfr_wr(sfr.sfr_wr), .sfr_rd(sfr.sfr_rd),
        .sfr_addr(sfr.sfr_addr), .sfr_wdata(sfr.sfr_wdata), .sfr_rdata(sfr.sfr_rdata),
        .sfr_rvalid(sfr.sfr_rvalid), .ints_enabled(sfr.ints_enabled),
        .debug_port_en(sfr.debug_port_en), .erase_busy(sfr.erase_busy));
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // pulses counted mid-cycle so the main sequence never races them
    always @(negedge clk)
    begin
        npe += pe;
        nme += me;
        nfw += fw;
        nxw += xw;
    end
    task conclude;
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task hang;
        mismatches++;
        $display("CHECK FAILED %0t wait ran out", $time);
        conclude();
    endtask : hang
    task hold;
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 40);
        if (hready !== 1'b1)
            hang();
    endtask : hold
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        hold();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        hold();
        rd = hrdata;
    endtask : ahb
    task poll(input logic [7:0] a, input int b, input logic v);
        int n;
        n = 0;
        do
        begin
            ahb(1'b0, a, 32'h0);
            n++;
        end while (rd[b] !== v && n < 30);
        if (rd[b] !== v)
            hang();
    endtask : poll
    task sw(input logic [7:0] a, input logic [7:0] d);
        ahb(1'b1, FPE_REG_SFR_CMD, {16'h0, d, a});
        poll(FPE_REG_STATUS, 0, 1'b0);
    endtask : sw
    task sr(input logic [7:0] a, input logic [7:0] exp);
        ahb(1'b1, FPE_REG_SFR_CMD, {15'h0, 1'b1, 8'h0, a});
        poll(FPE_REG_IRQ_STAT, FPE_IRQ_RDONE, 1'b1);
        ahb(1'b1, FPE_REG_IRQ_STAT, 32'h1);
        ahb(1'b0, FPE_REG_STATUS, 32'h0);
        chk({24'h0, rd[15:8]}, {24'h0, exp});
    endtask : sr
    task edone;
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        @(posedge clk);
    endtask : edone
    task rst;
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
    endtask : rst
    initial
    begin
        {rst_b, hsel, hwrite, done, htrans, col, haddr, hwdata} = '0;
        {mismatches, compares, npe, nme, nfw, nxw} = '0;
        rst();
        // rows: interrupts enabled, bit written, program enable read back
        foreach (rows[i])
        begin
            ahb(1'b1, FPE_REG_CTRL, {31'h0, rows[i][2]});
            sw(FPE_SFR_WRITE_CTL, {7'h0, rows[i][1]});
            sr(FPE_SFR_WRITE_CTL, {7'h0, rows[i][0]});
        end
        // reset lands in the middle of a page erase
        sw(FPE_SFR_ERASE_CMD, FPE_KEY_PAGE);
        rst();
        foreach (ha[i])
        begin
            ahb(1'b0, ha[i], 32'h0);
            chk(rd, 32'h0);
        end
        foreach (ra[i])
            sr(ra[i], re[i]);
        // counts are cumulative: one page pulse came before the reset
        sw(FPE_SFR_PAGE_NUM, 8'hfc);
        sw(FPE_SFR_ERASE_CMD, FPE_KEY_PAGE);
        chk(npe, 2);
        chk({25'h0, fpage}, 32'h7f);
        sw(FPE_SFR_ERASE_CMD, FPE_KEY_PAGE);
        sw(FPE_SFR_ERASE_CMD, FPE_KEY_MASS);
        chk(npe + nme, 2);
        edone();
        ahb(1'b0, FPE_REG_STATUS, 32'h0);
        chk({31'h0, rd[1]}, 32'h1);
        sw(FPE_SFR_ERASE_CMD, FPE_KEY_DONE);
        ahb(1'b0, FPE_REG_IRQ_STAT, 32'h0);
        chk({30'h0, rd[1], irq}, 32'h2);
        ahb(1'b1, FPE_REG_IRQ_MASK, 32'h2);
        ahb(1'b0, FPE_REG_STATUS, 32'h0);
        chk({30'h0, rd[1], irq}, 32'h1);
        ahb(1'b1, FPE_REG_IRQ_STAT, 32'h2);
        ahb(1'b0, FPE_REG_IRQ_STAT, 32'h0);
        chk({30'h0, rd[1], irq}, 32'h0);
        foreach (bk[i])
            sw(FPE_SFR_ERASE_CMD, bk[i]);
        chk(npe + nme, 2);
        ahb(1'b1, FPE_REG_CTRL, 32'h2);
        sw(FPE_SFR_ERASE_CMD, FPE_KEY_MASS);
        chk(nme, 0);
        ahb(1'b1, FPE_REG_CTRL, 32'h0);
        sw(FPE_SFR_WRITE_CTL, 8'h02);
        sw(FPE_SFR_ERASE_CMD, FPE_KEY_MASS);
        chk(nme, 0);
        ahb(1'b1, FPE_REG_CTRL, 32'h2);
        sw(FPE_SFR_WRITE_CTL, 8'h02);
        sw(FPE_SFR_ERASE_CMD, FPE_KEY_MASS);
        chk(nme, 1);
        sw(FPE_SFR_ERASE_CMD, FPE_KEY_DONE);
        edone();
        ahb(1'b0, FPE_REG_STATUS, 32'h0);
        chk({31'h0, rd[1]}, 32'h0);
        sw(FPE_SFR_ERASE_CMD, FPE_KEY_MASS);
        chk(nme, 1);
        ahb(1'b1, FPE_REG_CTRL, 32'h6);
        sw(FPE_SFR_ERASE_CMD, FPE_KEY_MASS);
        chk(nme, 2);
        sw(FPE_SFR_ERASE_CMD, FPE_KEY_DONE);
        edone();
        ahb(1'b1, FPE_REG_SFR_CMD, 32'h1_00b6);
        ahb(1'b1, FPE_REG_SFR_CMD, 32'h5594);
        ahb(1'b0, FPE_REG_IRQ_STAT, 32'h0);
        chk(rd[2] + 2 * npe, 5);
        ahb(1'b1, FPE_REG_IRQ_STAT, 32'h7);
        // flash byte through a moved bank, then a plain ram store
        sw(FPE_SFR_BANK_SEL, 8'h02);
        sw(FPE_SFR_WRITE_CTL, 8'h01);
        ahb(1'b1, FPE_REG_CTRL, 32'h8);
        ahb(1'b1, FPE_REG_XMOVE, 32'h005a_8123);
        poll(FPE_REG_STATUS, 0, 1'b0);
        chk({6'h0, faddr, fdata}, {6'h0, 3'h2, 15'h0123, 8'h5a});
        chk(nfw + nxw, 1);
        ahb(1'b1, FPE_REG_XMOVE, 32'h00a5_0456);
        poll(FPE_REG_STATUS, 0, 1'b0);
        chk({nfw[7:0], nxw[7:0], xaddr}, 32'h0101_0456);
        chk({hresp, 15'h0, xdata, fdata}, 32'h0000_a55a);
        col <= 2'b10;
        @(posedge clk);
        col <= 2'b00;
        sr(FPE_SFR_INT_FLAGS, 8'h08);
        sw(FPE_SFR_INT_FLAGS, 8'h04);
        sr(FPE_SFR_INT_FLAGS, 8'h04);
        conclude();
    end
endmodule : flash_program_erase_control_bench
`default_nettype wire
